// *** pmul_consts.vh ***
// constants of the pipelined multiplier: bus offsets, fields, reset values
// assumes inclusion by pmul_top.v and pmul_stage.v
// Overview of operation
// - optional squaring: first operand times itself
// - first operand width parameter, 1 to 256
// - second operand width parameter, 1 to 256
// - product width automatic or restricted 1-256
// - narrower product keeps only the most significant bits
// - second operand optionally a build-time constant
// - signed or unsigned multiply chosen at build
// - configurable latency, zero gives combinational product
// - async active-high clear zeroes all stages
// - sync active-high clear zeroes stages next edge
// - active-high clock enable gates pipeline, no default: tie high when unused
`ifndef PMUL_CONSTS_VH
`define PMUL_CONSTS_VH

// default build parameters
`define PMUL_DEF_A_W        16
`define PMUL_DEF_B_W        16
`define PMUL_DEF_P_W        32
`define PMUL_DEF_LATENCY    0
`define PMUL_W_MIN          1
`define PMUL_W_MAX          256

// register byte offsets
`define PMUL_ADDR_W         4
`define PMUL_OFF_CTRL       4'h0
`define PMUL_OFF_PROD_LO    4'h4
`define PMUL_OFF_CFG        4'h8
`define PMUL_OFF_STAT       4'hc

// control register fields
`define PMUL_CTRL_RUN_BIT   0
`define PMUL_CTRL_CLR_BIT   1
`define PMUL_CTRL_RESET     1'b1

// configuration register fields
`define PMUL_CFG_A_LSB      0
`define PMUL_CFG_B_LSB      9
`define PMUL_CFG_P_LSB      18
`define PMUL_CFG_SQ_BIT     27
`define PMUL_CFG_CONST_BIT  28
`define PMUL_CFG_SIGN_BIT   29

// status register fields
`define PMUL_STAT_EN_BIT    0
`define PMUL_STAT_CLR_BIT   1
`define PMUL_STAT_NZ_BIT    2

// bus responses
`define PMUL_RESP_OKAY      2'b00
`define PMUL_RESP_SLVERR    2'b10

`endif

// *** pmul_stage.v ***
// one pipeline register stage of the multiplier
// assumes a single clock; clears are active high
`timescale 1ns/1ps
`include "pmul_consts.vh"

module pmul_stage #(
    parameter W = `PMUL_DEF_P_W
) (
    input  wire         clk,
    input  wire         aclr,
    input  wire         sclr,
    input  wire         en,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    always @(posedge clk or posedge aclr) begin
        if (aclr) begin
            q <= {W{1'b0}};
        end else if (sclr) begin
            q <= {W{1'b0}};
        end else if (en) begin
            q <= d;
        end
    end

endmodule

// *** pmul_top.v ***
// parameterisable integer multiplier with optional output pipeline
// and an axi4-lite slave for control, status and product readback
// assumes operands synchronous to aclk; unused clear inputs tied low,
// unused enable tied high by the user logic
`timescale 1ns/1ps
`include "pmul_consts.vh"

module pmul_top #(
    parameter A_W       = `PMUL_DEF_A_W,
    parameter B_W       = `PMUL_DEF_B_W,
    parameter AUTO_W    = 1,
    parameter P_W_SEL   = `PMUL_DEF_P_W,
    parameter SQUARE    = 0,
    parameter B_CONST   = 0,
    parameter [255:0] B_VALUE = 256'h0,
    parameter SIGNED    = 0,
    parameter LATENCY   = `PMUL_DEF_LATENCY,
    parameter P_W       = AUTO_W ? (A_W + (SQUARE ? A_W : B_W)) : P_W_SEL
) (
    input  wire                    aclk,
    input  wire                    aresetn,
    // operands and product
    input  wire [A_W-1:0]          first_operand,
    input  wire [B_W-1:0]          second_operand,
    input  wire                    clken,
    input  wire                    aclr,
    input  wire                    sclr,
    output wire [P_W-1:0]          product,
    // axi4-lite slave
    input  wire [`PMUL_ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]              s_axi_awprot,
    input  wire                    s_axi_awvalid,
    output wire                    s_axi_awready,
    input  wire [31:0]             s_axi_wdata,
    input  wire [3:0]              s_axi_wstrb,
    input  wire                    s_axi_wvalid,
    output wire                    s_axi_wready,
    output wire [1:0]              s_axi_bresp,
    output wire                    s_axi_bvalid,
    input  wire                    s_axi_bready,
    input  wire [`PMUL_ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]              s_axi_arprot,
    input  wire                    s_axi_arvalid,
    output wire                    s_axi_arready,
    output wire [31:0]             s_axi_rdata,
    output wire [1:0]              s_axi_rresp,
    output wire                    s_axi_rvalid,
    input  wire                    s_axi_rready
);

    // effective second operand width and full product width
    localparam EB_W = SQUARE ? A_W : B_W;
    localparam F_W  = A_W + EB_W;
    localparam X_W  = F_W + 1;

    // ------------------------------------------------------------------
    // operand selection
    // ------------------------------------------------------------------
    // squaring or a constant b leaves second_operand unread
    wire [EB_W-1:0] opb;

    generate
        if (SQUARE != 0) begin : g_square
            assign opb = first_operand;
        end else if (B_CONST != 0) begin : g_const
            assign opb = B_VALUE[EB_W-1:0];
        end else begin : g_live
            assign opb = second_operand;
        end
    endgenerate

    // ------------------------------------------------------------------
    // extension to a common signed width, then multiply
    // ------------------------------------------------------------------
    wire            a_fill;
    wire            b_fill;
    wire [X_W-1:0]  a_x;
    wire [X_W-1:0]  b_x;
    wire [2*X_W-1:0] raw;
    wire [F_W-1:0]  full;

    assign a_fill = (SIGNED != 0) ? first_operand[A_W-1] : 1'b0;
    assign b_fill = (SIGNED != 0) ? opb[EB_W-1] : 1'b0;
    assign a_x    = {{(X_W-A_W){a_fill}}, first_operand};
    assign b_x    = {{(X_W-EB_W){b_fill}}, opb};
    // one spare bit lets unsigned operands ride a signed multiply
    assign raw    = $signed(a_x) * $signed(b_x);
    // the true product always fits in F_W bits
    assign full   = raw[F_W-1:0];

    // ------------------------------------------------------------------
    // product width: keep the top bits or extend
    // ------------------------------------------------------------------
    wire [P_W-1:0] prod_c;

    generate
        if (P_W <= F_W) begin : g_trunc
            assign prod_c = full[F_W-1 -: P_W];
        end else begin : g_ext
            // wider than full precision: the top is sign or zero filled
            wire top_fill;
            assign top_fill = (SIGNED != 0) ? full[F_W-1] : 1'b0;
            assign prod_c   = {{(P_W-F_W){top_fill}}, full};
        end
    endgenerate

    // ------------------------------------------------------------------
    // control register, software clear pulse
    // ------------------------------------------------------------------
    // run resets high so the block multiplies without any bus access
    reg  run_q;
    reg  run_d;
    reg  swclr_q;
    reg  swclr_d;
    wire pipe_en;
    wire pipe_sclr;

    // pipeline advances only with the external enable and the run bit
    assign pipe_en   = clken & run_q;
    // bus reset also empties the pipeline
    assign pipe_sclr = sclr | swclr_q | ~aresetn;

    // ------------------------------------------------------------------
    // pipeline chain
    // ------------------------------------------------------------------
    // stage_w[0] is the combinational product, stage_w[LATENCY] the output
    wire [P_W-1:0] stage_w [0:LATENCY];

    assign stage_w[0] = prod_c;

    // aclr reaches every stage at once; the other clears wait for an edge
    genvar gi;
    generate
        for (gi = 0; gi < LATENCY; gi = gi + 1) begin : g_pipe
            pmul_stage #(
                .W    (P_W)
            ) u_stage (
                .clk  (aclk),
                .aclr (aclr),
                .sclr (pipe_sclr),
                .en   (pipe_en),
                .d    (stage_w[gi]),
                .q    (stage_w[gi+1])
            );
        end
    endgenerate

    // zero latency passes the combinational product straight out
    assign product = stage_w[LATENCY];

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    reg                    aw_have_q;
    reg                    aw_have_d;
    reg [`PMUL_ADDR_W-1:0] aw_addr_q;
    reg [`PMUL_ADDR_W-1:0] aw_addr_d;
    reg                    w_have_q;
    reg                    w_have_d;
    reg [31:0]             w_data_q;
    reg [31:0]             w_data_d;
    reg [3:0]              w_strb_q;
    reg [3:0]              w_strb_d;
    reg                    bvalid_q;
    reg                    bvalid_d;
    reg [1:0]              bresp_q;
    reg [1:0]              bresp_d;
    wire                   aw_take;
    wire                   w_take;
    wire                   wr_go;

    // address and data may come in either order; the answer waits for both
    // and neither is taken again until that answer has been accepted
    assign s_axi_awready = ~aw_have_q & ~bvalid_q;
    assign s_axi_wready  = ~w_have_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign wr_go         = aw_have_q & w_have_q & ~bvalid_q;

    always @* begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        run_d     = run_q;
        swclr_d   = 1'b0;
        if (aw_take) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (w_take) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb_d = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `PMUL_RESP_OKAY;
            case (aw_addr_q)
                `PMUL_OFF_CTRL: begin
                    if (w_strb_q[0]) begin
                        run_d   = w_data_q[`PMUL_CTRL_RUN_BIT];
                        swclr_d = w_data_q[`PMUL_CTRL_CLR_BIT];
                    end
                end
                // read-only words ignore writes but answer okay
                `PMUL_OFF_PROD_LO,
                `PMUL_OFF_CFG,
                `PMUL_OFF_STAT: begin
                    bresp_d = `PMUL_RESP_OKAY;
                end
                default: begin
                    bresp_d = `PMUL_RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= {`PMUL_ADDR_W{1'b0}};
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `PMUL_RESP_OKAY;
            run_q     <= `PMUL_CTRL_RESET;
            swclr_q   <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            run_q     <= run_d;
            swclr_q   <= swclr_d;
        end
    end

    // ------------------------------------------------------------------
    // readable state
    // ------------------------------------------------------------------
    wire [31:0] prod_lo;
    wire [31:0] cfg_word;
    wire [31:0] stat_word;

    generate
        if (P_W >= 32) begin : g_lo_wide
            assign prod_lo = product[31:0];
        end else begin : g_lo_narrow
            assign prod_lo = {{(32-P_W){1'b0}}, product};
        end
    endgenerate

    // widths stored minus one so that 512 fits nine bits
    assign cfg_word = {2'b00,
                       (SIGNED != 0) ? 1'b1 : 1'b0,
                       (B_CONST != 0) ? 1'b1 : 1'b0,
                       (SQUARE != 0) ? 1'b1 : 1'b0,
                       P_W[8:0] - 9'h001,
                       EB_W[8:0] - 9'h001,
                       A_W[8:0] - 9'h001};

    assign stat_word = {29'h0000_0000,
                        |product,
                        pipe_sclr,
                        pipe_en};

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    reg        rvalid_q;
    reg        rvalid_d;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg [1:0]  rresp_q;
    reg [1:0]  rresp_d;
    wire       ar_take;

    // one read under way at most: the address waits while an answer stands
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign ar_take       = s_axi_arvalid & ~rvalid_q;

    always @* begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (ar_take) begin
            rvalid_d = 1'b1;
            rresp_d  = `PMUL_RESP_OKAY;
            case (s_axi_araddr)
                `PMUL_OFF_CTRL: begin
                    rdata_d = {31'h0000_0000, run_q};
                end
                `PMUL_OFF_PROD_LO: begin
                    rdata_d = prod_lo;
                end
                `PMUL_OFF_CFG: begin
                    rdata_d = cfg_word;
                end
                `PMUL_OFF_STAT: begin
                    rdata_d = stat_word;
                end
                // unmapped words read as zero with an error answer
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `PMUL_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `PMUL_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

endmodule

// *** pmul_chk.sv ***
// port assertions for the multiplier: datapath timing, clears, bus answers
// assumes binding into pmul_top; latency and stall checks stop once ctrl is written
`timescale 1ns/1ps
module pmul_chk #(
    parameter A_W     = 8,
    parameter B_W     = 6,
    parameter P_W     = 10,
    parameter LATENCY = 2,
    parameter SIGNED  = 1
) (
    input wire           aclk,
    input wire           aresetn,
    input wire [A_W-1:0] first_operand,
    input wire [B_W-1:0] second_operand,
    input wire           clken,
    input wire           aclr,
    input wire           sclr,
    input wire [P_W-1:0] product,
    input wire [3:0]     s_axi_awaddr,
    input wire           s_axi_awvalid,
    input wire           s_axi_awready,
    input wire           s_axi_wvalid,
    input wire           s_axi_wready,
    input wire [1:0]     s_axi_bresp,
    input wire           s_axi_bvalid,
    input wire           s_axi_bready,
    input wire           s_axi_arvalid,
    input wire           s_axi_arready,
    input wire [31:0]    s_axi_rdata,
    input wire           s_axi_rvalid,
    input wire           s_axi_rready
);
    localparam N = A_W + B_W;
    wire signed [N-1:0] full_s = $signed(first_operand) * $signed(second_operand);
    wire [N-1:0]        full_u = first_operand * second_operand;
    wire [N-1:0]        full   = SIGNED ? full_s : full_u;
    wire [P_W-1:0]      hi     = full[N-1 -: P_W];
    reg  [3:0]          clean_q;
    reg                 ctl_q;
    // counts edges in a row at which the pipeline advanced
    always @(posedge aclk) begin
        if (!aresetn) begin
            clean_q <= 4'h0;
            ctl_q   <= 1'b0;
        end else begin
            if (!clken || sclr || aclr)
                clean_q <= 4'h0;
            else if (clean_q != 4'hf)
                clean_q <= clean_q + 4'h1;
            if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h0)
                ctl_q <= 1'b1;
        end
    end
    property p_lat;
        @(posedge aclk) disable iff (!aresetn || ctl_q)
        clean_q >= LATENCY && !aclr |-> product == $past(hi, LATENCY);
    endproperty
    a_lat: assert property (p_lat) else $error("product mismatch");
    property p_hold;
        @(posedge aclk) disable iff (!aresetn || ctl_q)
        !clken && !sclr && !aclr ##1 !aclr |-> $stable(product);
    endproperty
    a_hold: assert property (p_hold) else $error("product moved while stalled");
    property p_sclr;
        @(posedge aclk) disable iff (!aresetn) sclr |=> product == '0;
    endproperty
    a_sclr: assert property (p_sclr) else $error("sync clear missed");
    property p_aclr;
        @(posedge aclk) disable iff (!aresetn) aclr |-> product == '0;
    endproperty
    a_aclr: assert property (p_aclr) else $error("async clear missed");
    property p_bhold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_rlat;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_blat;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_busy;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    a_busy: assert property (p_busy) else $error("request taken while answer pending");
endmodule

bind pmul_top pmul_chk #(.A_W(A_W), .B_W(B_W), .P_W(P_W), .LATENCY(LATENCY), .SIGNED(SIGNED))
    pmul_chk_inst (.aclk, .aresetn, .first_operand, .second_operand, .clken, .aclr, .sclr,
    .product, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// *** pmul_user.sv ***
// user logic model: new random operands every cycle, enable stalls when slow
// assumes one clock; corner forces the most negative operands
`timescale 1ns/1ps
module pmul_user (
    input  wire       aclk,
    input  wire       slow,
    input  wire       corner,
    output reg  [7:0] first_operand,
    output reg  [5:0] second_operand,
    output reg        clken
);
    integer    seed = 96292;
    reg [31:0] r;
    initial begin
        first_operand = 8'h00;
        second_operand = 6'h00;
        clken = 1'b1;
    end
    always @(posedge aclk) begin
        r = $random(seed);
        first_operand <= corner ? 8'h80 : r[7:0];
        second_operand <= corner ? 6'h20 : r[13:8];
        clken <= !slow || r[16];
    end
endmodule

// *** pmul_top_tb.sv ***
// self-checking bench: random operand stream, stalls, clears, register access
// assumes pmul_top with the checker bound beside it
`timescale 1ns/1ps
module pmul_top_tb;
    localparam [31:0] CFG_EXP = {2'b00, 1'b1, 2'b00, 9'd9, 9'd5, 9'd7};
    localparam A_W = 8, B_W = 6, P_W = 10, LAT = 2, SGN = 1, AUTO = 0;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         aclr = 1'b0;
    reg         sclr = 1'b0;
    reg         slow = 1'b0;
    reg         corner = 1'b0;
    reg         chk_on = 1'b0;
    reg  [3:0]  s_axi_awaddr = 4'h0;
    reg  [3:0]  s_axi_araddr = 4'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'hf;
    reg  [2:0]  s_axi_awprot = 3'h0;
    reg  [2:0]  s_axi_arprot = 3'h0;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_rready = 1'b0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0]  first_operand;
    wire [5:0]  second_operand;
    wire        clken;
    wire [9:0]  product;
    reg  [9:0]  s1 = 10'h0;
    reg  [9:0]  s2 = 10'h0;
    reg  [9:0]  held;
    reg  [1:0]  resp;
    reg  [31:0] rd;
    integer     fail_count = 0;
    integer     n_compared = 0;

    always #5 aclk = ~aclk;

    pmul_top #(.A_W(A_W), .B_W(B_W), .AUTO_W(AUTO), .P_W_SEL(P_W), .SIGNED(SGN), .LATENCY(LAT))
        pmul_top_inst (.aclk, .aresetn, .first_operand, .second_operand, .clken, .aclr,
        .sclr, .product, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    pmul_user pmul_user_inst (.aclk, .slow, .corner, .first_operand, .second_operand, .clken);

    // top bits of the signed full product
    function [9:0] mul_hi(input [7:0] x, input [5:0] y);
        reg signed [13:0] p;
        begin
            p = $signed(x) * $signed(y);
            mul_hi = p[13:4];
        end
    endfunction

    // reference two-stage pipeline
    always @(posedge aclk or posedge aclr) begin
        if (aclr || sclr || !aresetn) begin
            s1 <= 10'h0;
            s2 <= 10'h0;
        end else if (clken) begin
            s1 <= mul_hi(first_operand, second_operand);
            s2 <= s1;
        end
    end

    task chk(input [63:0] seen, input [63:0] exp, input [8*8:1] what);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    always @(negedge aclk) if (chk_on) chk(product, s2, "product");

    task report_and_stop;
        begin
            $display("compared %0d mismatched %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task wr_reg(input [3:0] ad, input [31:0] d, output [1:0] r);
        reg     done;
        begin
            r = 2'b01;
            done = 1'b0;
            s_axi_awaddr <= ad;
            s_axi_awprot <= d[2:0];
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            // waits for the answer; only the watchdog ends a hang
            while (!done) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid && s_axi_bready) begin
                    r = s_axi_bresp;
                    done = 1'b1;
                    s_axi_bready <= 1'b0;
                end else if (s_axi_bvalid)
                    s_axi_bready <= 1'b1;
            end
        end
    endtask

    task rd_reg(input [3:0] ad, output [31:0] d, output [1:0] r);
        reg     done;
        begin
            r = 2'b01;
            d = 32'h0;
            done = 1'b0;
            s_axi_araddr <= ad;
            s_axi_arprot <= ad[2:0];
            s_axi_arvalid <= 1'b1;
            while (!done) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid && s_axi_rready) begin
                    d = s_axi_rdata;
                    r = s_axi_rresp;
                    done = 1'b1;
                    s_axi_rready <= 1'b0;
                end else if (s_axi_rvalid)
                    s_axi_rready <= 1'b1;
            end
        end
    endtask

    initial begin
        #20000;
        fail_count = fail_count + 1;
        report_and_stop;
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk_on <= 1'b1;
        repeat (40) @(posedge aclk);
        $display("test random stream done");
        slow <= 1'b1;
        repeat (40) @(posedge aclk);
        $display("test stalled stream done");
        corner <= 1'b1;
        repeat (4) @(posedge aclk);
        corner <= 1'b0;
        sclr <= 1'b1;
        @(posedge aclk);
        sclr <= 1'b0;
        repeat (5) @(posedge aclk);
        aclr <= 1'b1;
        #1 chk(product, 0, "aclr");
        @(posedge aclk);
        aclr <= 1'b0;
        repeat (5) @(posedge aclk);
        $display("test corners and clears done");
        slow <= 1'b0;
        chk_on <= 1'b0;
        rd_reg(4'h8, rd, resp);
        chk(rd, CFG_EXP, "cfg");
        rd_reg(4'h0, rd, resp);
        chk(rd, 32'h1, "ctrl");
        // run bit sits in byte 0: a write without that strobe leaves it set
        s_axi_wstrb <= 4'he;
        wr_reg(4'h0, 32'h0, resp);
        s_axi_wstrb <= 4'hf;
        rd_reg(4'h0, rd, resp);
        chk({resp, rd}, {2'b00, 32'h1}, "strb");
        rd_reg(4'h2, rd, resp);
        chk({resp, rd}, {2'b10, 32'h0}, "unmapped");
        wr_reg(4'h8, 32'h0, resp);
        chk(resp, 2'b00, "bresp");
        rd_reg(4'h8, rd, resp);
        chk(rd, CFG_EXP, "cfg_ro");
        wr_reg(4'h0, 32'h0, resp);
        @(negedge aclk) held = product;
        repeat (5) @(posedge aclk);
        chk(product, held, "stopped");
        rd_reg(4'h4, rd, resp);
        chk(rd, {22'h0, held}, "prod_lo");
        rd_reg(4'hc, rd, resp);
        chk(rd, {29'h0, |held, 2'b00}, "stat");
        wr_reg(4'h0, 32'h3, resp);
        // the clear pulse empties both stages before the answer is taken
        @(negedge aclk) chk(product, 0, "swclr");
        sclr <= 1'b1;
        @(posedge aclk);
        sclr <= 1'b0;
        chk_on <= 1'b1;
        repeat (20) @(posedge aclk);
        $display("test registers done");
        // mid-run reset: pipeline empties and the run bit comes back set
        chk_on <= 1'b0;
        wr_reg(4'h0, 32'h0, resp);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_on <= 1'b1;
        rd_reg(4'h0, rd, resp);
        chk(rd, 32'h1, "ctrl_rst");
        repeat (20) @(posedge aclk);
        $display("test mid-run reset done");
        report_and_stop;
    end
endmodule
